// File: pkg/vct_pkg.sv
// Constants, register indices and video carrier types for the CRT timing block
package vct_pkg;
    // I/O port addresses for the two addressing modes
    localparam logic [15:0] VCT_INDEX_MONO  = 16'h03b4;
    localparam logic [15:0] VCT_DATA_MONO   = 16'h03b5;
    localparam logic [15:0] VCT_INDEX_COLOR = 16'h03d4;
    localparam logic [15:0] VCT_DATA_COLOR  = 16'h03d5;
    // Register indices
    localparam logic [7:0] IDX_HORIZONTAL_TOTAL       = 8'h00;
    localparam logic [7:0] IDX_HORIZONTAL_DISPLAY_END = 8'h01;
    localparam logic [7:0] IDX_HORIZONTAL_BLANK_START = 8'h02;
    localparam logic [7:0] IDX_HORIZONTAL_BLANK_END   = 8'h03;
    localparam logic [7:0] IDX_HORIZONTAL_SYNC_START  = 8'h04;
    localparam logic [7:0] IDX_HORIZONTAL_SYNC_END    = 8'h05;
    localparam logic [7:0] IDX_VERTICAL_TOTAL_LOW     = 8'h06;
    localparam logic [7:0] IDX_VERTICAL_HIGH_BITS     = 8'h07;
    localparam logic [7:0] IDX_PRESET_ROW_PANNING     = 8'h08;
    localparam logic [7:0] IDX_ROW_HEIGHT_CONTROL     = 8'h09;
    localparam logic [7:0] IDX_TEXT_CURSOR_START      = 8'h0a;
    localparam logic [7:0] IDX_TEXT_CURSOR_END        = 8'h0b;
    localparam logic [7:0] IDX_DISPLAY_START_HIGH     = 8'h0c;
    localparam logic [7:0] IDX_DISPLAY_START_LOW      = 8'h0d;
    localparam logic [7:0] IDX_CURSOR_LOCATION_HIGH   = 8'h0e;
    localparam logic [7:0] IDX_CURSOR_LOCATION_LOW    = 8'h0f;
    localparam logic [7:0] IDX_VSYNC_START_LOW        = 8'h10;
    localparam logic [7:0] IDX_VSYNC_END_CONTROL      = 8'h11;
    localparam logic [7:0] IDX_VDISPLAY_END_LOW       = 8'h12;
    localparam int         VCT_NUM_REGS               = 19;
    localparam logic [7:0] VCT_LAST_PROTECTED         = 8'h07;
    // Index field selecting the extended bank
    localparam logic [1:0] VCT_EXT_BANK               = 2'b10;
    // Field positions
    localparam int BIT_VSYNC_ACCESS_GATE   = 7;
    localparam int BIT_BLANK_END_BIT5      = 7;
    localparam int BIT_LINE_DOUBLING       = 7;
    localparam int BIT_CURSOR_OFF          = 5;
    localparam int BIT_WRITE_PROTECT       = 7;
    localparam int BIT_REFRESH_COUNT_SEL   = 6;
    localparam int BIT_LC8_IN_HIGH_BITS    = 4;
    localparam int SKEW_LSB                = 5;
    // Reset value of every stored register
    localparam logic [7:0] VCT_REG_RESET   = 8'h00;
    // Count offsets between programmed values and real spans
    localparam logic [8:0] VCT_HTOTAL_ADJ  = 9'd5;
    localparam logic [9:0] VCT_VTOTAL_ADJ  = 10'd2;

    // Registered video outputs
    typedef struct packed {
        logic display_enable;
        logic blank;
        logic hsync;
        logic vsync;
        logic cursor;
    } vct_video_t;

    // Memory fetch information
    typedef struct packed {
        logic [15:0] fetch_addr;
        logic [4:0]  row_scan;
        logic [1:0]  byte_pan;
    } vct_fetch_t;
endpackage

// File: verilog/vct_crtc.sv
// CRT controller register bank and display timing generator
`timescale 1ns/1ps
//
// Behaviour
// - Data port reads or writes the register chosen by index; mono or color address.
// - Horizontal total equals character clocks per scanline minus five.
// - Horizontal display end equals active character clocks minus one.
// - Blank end bit 7 gates access to vertical sync start and end.
// - Display enable skew delays display enable zero to three characters.
// - Six-bit blanking width; bit 5 in sync end bit 7; stays within total.
// - Sync delay field postpones horizontal sync by zero to three characters.
// - Five-bit sync width in character clocks, kept within horizontal total.
// - Ten-bit vertical total equals scanlines per frame minus two.
// - High-bits register holds the listed ninth and eighth bits.
// - Byte panning shifts display left by zero to three bytes.
// - Preset row picks the starting scanline of the first character row.
// - Row height minus one in bits 4:0, plus line compare and blank bits.
// - Line doubling bit shows every scanline twice.
// - Cursor spans start to end scanline; start bit 5 high turns it off.
// - Cursor skew delays the cursor zero to three character clocks.
// - High and low bytes form the sixteen-bit display start address.
// - High and low bytes form the sixteen-bit cursor address.
// - Ten-bit vertical sync start, high bits in the high-bits register.
// - Protect bit blocks writes to indices 0..7 except line compare bit 8.
// - Refresh count select is stored only and changes nothing.
// - Extended bank selected only when index bits 7:6 are binary 10.
module vct_crtc (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // Character clock strobe and address mode from the sequencer side
    input  wire logic               char_tick,
    input  wire logic               color_mode,
    // Host I/O port
    input  wire logic [15:0]        io_addr,
    input  wire logic               io_wr,
    input  wire logic               io_rd,
    input  wire logic [7:0]         io_wdata,
    output logic      [7:0]         io_rdata,
    output logic                    io_rvalid,
    // Extended register bank select
    output logic                    ext_sel,
    // Video timing toward the monitor and fetch logic
    output vct_pkg::vct_video_t     video,
    output vct_pkg::vct_fetch_t     fetch
);
    import vct_pkg::*;

    logic [7:0]  regs [0:VCT_NUM_REGS-1];
    logic [7:0]  register_select_index;
    logic [15:0] index_addr;
    logic [15:0] data_addr;
    logic        data_wr;
    logic        data_rd;
    logic        index_wr;
    logic        index_rd;
    logic        idx_in_range;
    logic        idx_is_vsync;
    logic        vsync_access_gate;
    logic        reg_ok;
    logic        write_protect;
    logic [4:0]  idx_lo;

    // Decoded fields
    logic [8:0]  htotal_last;
    logic [7:0]  hdisp_end;
    logic [7:0]  hblank_start;
    logic [5:0]  hblank_width;
    logic [7:0]  hsync_start;
    logic [4:0]  hsync_width;
    logic [1:0]  de_skew;
    logic [1:0]  hsync_delay;
    logic [9:0]  vtotal_last;
    logic [9:0]  vsync_start;
    logic [3:0]  vsync_width;
    logic [9:0]  vdisp_end;
    logic [1:0]  byte_pan_count;
    logic [4:0]  first_row_scanline;
    logic [4:0]  row_height;
    logic        line_doubling;
    logic        cursor_off;
    logic [4:0]  cursor_first;
    logic [4:0]  cursor_last;
    logic [1:0]  cursor_skew;
    logic [15:0] start_addr;
    logic [15:0] cursor_addr;

    // Counters and raw timing
    logic [8:0]  hcnt;
    logic [9:0]  vcnt;
    logic [4:0]  row_scan;
    logic        dbl_phase;
    logic [15:0] row_base;
    logic [15:0] char_addr;
    logic [8:0]  hblank_diff;
    logic [8:0]  hsync_diff;
    logic [9:0]  vsync_diff;
    logic        line_end;
    logic        frame_end;
    logic        row_advance;
    logic        hde_raw;
    logic        vde_raw;
    logic        hblank_raw;
    logic        hsync_raw;
    logic        vsync_raw;
    logic        cursor_raw;
    logic [2:0]  de_hist;
    logic [2:0]  hs_hist;
    logic [2:0]  cur_hist;
    logic        de_skewed;
    logic        hs_skewed;
    logic        cur_skewed;

    // Pick current value or one of the last three character samples
    function automatic logic skew_pick(input logic now, input logic [2:0] hist,
                                       input logic [1:0] code);
        logic res;
        res = now;
        case (code)
            2'd0:    res = now;
            2'd1:    res = hist[0];
            2'd2:    res = hist[1];
            2'd3:    res = hist[2];
            default: res = now;
        endcase
        return res;
    endfunction

    // Port decode follows the monochrome or color address pair
    assign index_addr = color_mode ? VCT_INDEX_COLOR : VCT_INDEX_MONO;
    assign data_addr  = color_mode ? VCT_DATA_COLOR : VCT_DATA_MONO;
    assign index_wr   = io_wr && (io_addr == index_addr);
    assign index_rd   = io_rd && (io_addr == index_addr);
    assign data_wr    = io_wr && (io_addr == data_addr);
    assign data_rd    = io_rd && (io_addr == data_addr);
    assign idx_lo     = register_select_index[4:0];

    // Extended bank is only the 10 pattern in the top two index bits
    assign ext_sel = register_select_index[7:6] == VCT_EXT_BANK;

    // Vertical sync pair hidden until the access gate is set
    assign vsync_access_gate = regs[3][BIT_VSYNC_ACCESS_GATE];
    assign idx_is_vsync = (register_select_index == IDX_VSYNC_START_LOW) ||
                          (register_select_index == IDX_VSYNC_END_CONTROL);
    assign idx_in_range = register_select_index < 8'(VCT_NUM_REGS);
    assign reg_ok = !ext_sel && idx_in_range &&
                    !(idx_is_vsync && !vsync_access_gate);
    assign write_protect = regs[17][BIT_WRITE_PROTECT];

    // Index register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            register_select_index <= VCT_REG_RESET;
        end else if (index_wr) begin
            register_select_index <= io_wdata;
        end
    end

    // Register bank writes; protection leaves line compare bit 8 open
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < VCT_NUM_REGS; i++) begin
                regs[i] <= VCT_REG_RESET;
            end
        end else if (data_wr && reg_ok) begin
            if (write_protect && register_select_index <= VCT_LAST_PROTECTED) begin
                if (register_select_index == IDX_VERTICAL_HIGH_BITS) begin
                    regs[7][BIT_LC8_IN_HIGH_BITS] <= io_wdata[BIT_LC8_IN_HIGH_BITS];
                end
            end else begin
                regs[idx_lo] <= io_wdata;
            end
        end
    end

    // Read data registered; blocked or unmapped selections read zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd;
            if (index_rd) begin
                io_rdata <= register_select_index;
            end else if (data_rd && reg_ok) begin
                io_rdata <= regs[idx_lo];
            end else begin
                io_rdata <= 8'h00;
            end
        end
    end

    // Field extraction from the bank
    assign htotal_last  = {1'b0, regs[0]} + VCT_HTOTAL_ADJ - 9'd1;
    assign hdisp_end    = regs[1];
    assign hblank_start = regs[2];
    assign hblank_width = {regs[5][BIT_BLANK_END_BIT5], regs[3][4:0]};
    assign de_skew      = regs[3][SKEW_LSB+1:SKEW_LSB];
    assign hsync_start  = regs[4];
    assign hsync_delay  = regs[5][SKEW_LSB+1:SKEW_LSB];
    assign hsync_width  = regs[5][4:0];
    assign vtotal_last  = {regs[7][5], regs[7][0], regs[6]} + VCT_VTOTAL_ADJ - 10'd1;
    assign vsync_start  = {regs[7][7], regs[7][2], regs[16]};
    assign vdisp_end    = {regs[7][6], regs[7][1], regs[18]};
    assign vsync_width  = regs[17][3:0];
    assign byte_pan_count     = regs[8][SKEW_LSB+1:SKEW_LSB];
    assign first_row_scanline = regs[8][4:0];
    assign row_height    = regs[9][4:0];
    assign line_doubling = regs[9][BIT_LINE_DOUBLING];
    assign cursor_off    = regs[10][BIT_CURSOR_OFF];
    assign cursor_first  = regs[10][4:0];
    assign cursor_last   = regs[11][4:0];
    assign cursor_skew   = regs[11][SKEW_LSB+1:SKEW_LSB];
    assign start_addr    = {regs[12], regs[13]};
    assign cursor_addr   = {regs[14], regs[15]};

    // Line and frame boundaries; >= so a lowered total cannot strand a counter
    assign line_end    = char_tick && (hcnt >= htotal_last);
    assign frame_end   = line_end && (vcnt >= vtotal_last);
    assign row_advance = !line_doubling || dbl_phase;

    // Character counter wraps at the horizontal total
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hcnt <= 9'd0;
        end else if (line_end) begin
            hcnt <= 9'd0;
        end else if (char_tick) begin
            hcnt <= hcnt + 9'd1;
        end
    end

    // Scanline counter wraps at the vertical total
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vcnt <= 10'd0;
        end else if (frame_end) begin
            vcnt <= 10'd0;
        end else if (line_end) begin
            vcnt <= vcnt + 10'd1;
        end
    end

    // Doubling phase: each character scanline is shown on two lines
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dbl_phase <= 1'b0;
        end else if (frame_end) begin
            dbl_phase <= 1'b0;
        end else if (line_end && line_doubling) begin
            dbl_phase <= !dbl_phase;
        end
    end

    // Row scan and row base; preset row sets where scrolling starts
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            row_scan <= 5'd0;
            row_base <= 16'h0000;
        end else if (frame_end) begin
            row_scan <= first_row_scanline;
            row_base <= start_addr;
        end else if (line_end && row_advance) begin
            if (row_scan >= row_height) begin
                row_scan <= 5'd0;
                row_base <= row_base + {8'h00, hdisp_end} + 16'h0001;
            end else begin
                row_scan <= row_scan + 5'd1;
            end
        end
    end

    // Character address walks the active part of each line
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            char_addr <= 16'h0000;
        end else if (frame_end) begin
            char_addr <= start_addr;
        end else if (line_end) begin
            if (row_advance && row_scan >= row_height) begin
                char_addr <= row_base + {8'h00, hdisp_end} + 16'h0001;
            end else begin
                char_addr <= row_base;
            end
        end else if (char_tick && hde_raw) begin
            char_addr <= char_addr + 16'h0001;
        end
    end

    // Window compares; software keeps each span inside its total
    assign hblank_diff = hcnt - {1'b0, hblank_start};
    assign hsync_diff  = hcnt - {1'b0, hsync_start};
    assign vsync_diff  = vcnt - vsync_start;
    assign hde_raw     = hcnt <= {1'b0, hdisp_end};
    assign vde_raw     = vcnt <= vdisp_end;
    assign hblank_raw  = (hcnt >= {1'b0, hblank_start}) &&
                         (hblank_diff < {3'b000, hblank_width});
    assign hsync_raw   = (hcnt >= {1'b0, hsync_start}) &&
                         (hsync_diff < {4'h0, hsync_width});
    assign vsync_raw   = (vcnt >= vsync_start) &&
                         (vsync_diff < {6'h00, vsync_width});
    assign cursor_raw  = !cursor_off && hde_raw && vde_raw &&
                         (char_addr == cursor_addr) &&
                         (row_scan >= cursor_first) && (row_scan <= cursor_last);

    // Character-wide history for the three skew selectors
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            de_hist  <= 3'b000;
            hs_hist  <= 3'b000;
            cur_hist <= 3'b000;
        end else if (char_tick) begin
            de_hist  <= {de_hist[1:0], hde_raw};
            hs_hist  <= {hs_hist[1:0], hsync_raw};
            cur_hist <= {cur_hist[1:0], cursor_raw};
        end
    end

    assign de_skewed  = skew_pick(hde_raw, de_hist, de_skew);
    assign hs_skewed  = skew_pick(hsync_raw, hs_hist, hsync_delay);
    assign cur_skewed = skew_pick(cursor_raw, cur_hist, cursor_skew);

    // Outputs from flip-flops to keep the monitor pins glitch free
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            video <= '0;
            fetch <= '0;
        end else begin
            video.display_enable <= de_skewed && vde_raw;
            video.blank          <= hblank_raw || !vde_raw;
            video.hsync          <= hs_skewed;
            video.vsync          <= vsync_raw;
            video.cursor         <= cur_skewed;
            fetch.fetch_addr     <= char_addr + {14'h0000, byte_pan_count};
            fetch.row_scan       <= row_scan;
            fetch.byte_pan       <= byte_pan_count;
        end
    end

    // Horizontal counter returns to zero after the last character
    a_hcnt_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        line_end |=> hcnt == 9'd0) else $error("hcnt did not wrap");

    // Display window closes right after display end
    a_hde_close: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (de_skew == 2'd0 && hcnt == {1'b0, hdisp_end} + 9'd1) |=> !video.display_enable)
        else $error("display enable past end");

    // Vertical counter wraps at total plus two lines
    a_vcnt_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        frame_end |=> vcnt == 10'd0 && row_scan == $past(first_row_scanline))
        else $error("vcnt or row scan wrong at frame start");

    // Protected horizontal total register holds its value across a write
    a_protect_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (data_wr && write_protect && register_select_index == IDX_HORIZONTAL_TOTAL)
        |=> $stable(regs[0])) else $error("protected write landed");

    // Gated vertical sync register reads zero
    a_gate_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (data_rd && !vsync_access_gate && idx_is_vsync) |=> io_rdata == 8'h00)
        else $error("gated register visible");

    // Extended bank write leaves the standard bank untouched
    a_ext_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (data_wr && ext_sel) |=> $stable(regs[idx_lo]))
        else $error("extended write hit bank");

    // Cursor pin stays low while switched off and unskewed
    a_cursor_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cursor_off && cursor_skew == 2'd0) |=> !video.cursor)
        else $error("cursor shown while off");

    // Zero skew passes display enable to the pin one clock later
    a_skew_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (de_skew == 2'd0 && vde_raw) |=> video.display_enable == $past(hde_raw))
        else $error("zero skew delayed");

    // Two-character sync delay shows the compare from two ticks back
    a_sync_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (hsync_delay == 2'd2 && $past(char_tick) && $past(char_tick, 2))
        |=> video.hsync == $past(hsync_raw, 3)) else $error("sync delay wrong");

    // No sync pulse reaches the pin when width is zero
    a_sync_width: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (hsync_width == 5'd0 && hsync_delay == 2'd0) |=> !video.hsync)
        else $error("sync with zero width");
endmodule

// File: verification/vct_monitor_model.sv
// Monitor model that times sync and enable pulses seen at the video outputs
`timescale 1ns/1ps
module vct_monitor_model
    import vct_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Video from the controller
    input  wire vct_video_t video,
    // Measured spans in system clocks; frame height and line count in scanlines
    output int              line_len,
    output int              hs_width,
    output int              de_width,
    output int              hs_off,
    output int              frame_lines,
    output int              lines,
    output int              bl_width,
    output int              cur_clks
);
    int   hs_cnt, hw_cnt, de_cnt, off_cnt, fl_cnt, bw_cnt;
    logic hs_q, de_q, vs_q, bl_q;
    // Edge timing; only valid while char_tick runs every clock
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {hs_q, de_q, vs_q, bl_q} <= 4'b0000;
            {hs_cnt, hw_cnt, de_cnt, off_cnt, fl_cnt, bw_cnt} <= '0;
            {line_len, hs_width, de_width, hs_off, frame_lines, lines} <= '0;
            {bl_width, cur_clks} <= '0;
        end else begin
            {hs_q, de_q, vs_q} <= {video.hsync, video.display_enable, video.vsync};
            bl_q <= video.blank;
            bw_cnt <= bw_cnt + 1;
            // Blank pulse width and clocks with the cursor lit
            if (video.blank && !bl_q) bw_cnt <= 1;
            if (!video.blank && bl_q) bl_width <= bw_cnt;
            if (video.cursor) cur_clks <= cur_clks + 1;
            hs_cnt <= hs_cnt + 1;
            off_cnt <= off_cnt + 1;
            hw_cnt <= hw_cnt + 1;
            de_cnt <= de_cnt + 1;
            if (video.display_enable && !de_q) begin
                off_cnt <= 1;
                de_cnt <= 1;
            end
            if (!video.display_enable && de_q) de_width <= de_cnt;
            if (!video.hsync && hs_q) hs_width <= hw_cnt;
            if (video.hsync && !hs_q) begin
                line_len <= hs_cnt;
                hs_off <= off_cnt;
                hs_cnt <= 1;
                hw_cnt <= 1;
                lines <= lines + 1;
                fl_cnt <= fl_cnt + 1;
            end
            // Lines between vsync starts give the frame height
            if (video.vsync && !vs_q) begin
                frame_lines <= fl_cnt;
                fl_cnt <= 0;
            end
        end
    end
endmodule

// File: verification/vct_crtc_tb.sv
// Self-checking testbench for the CRT controller registers and timing
`timescale 1ns/1ps
module vct_crtc_tb;
    import vct_pkg::*;
    logic        sys_clk, sys_rst, char_tick, color_mode, io_wr, io_rd, io_rvalid, ext_sel;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata;
    vct_video_t  video;
    vct_fetch_t  fetch;
    int          line_len, hs_width, de_width, hs_off, frame_lines, lines;
    int          bl_width, cur_clks, c0;
    int          mismatches, comparisons;
    logic [7:0]  tidx [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                               8'h12, 8'h10, 8'h11};
    logic [7:0]  tval [11] = '{8'h14, 8'h09, 8'h0c, 8'h85, 8'h0e, 8'h04, 8'h03, 8'h00,
                               8'h04, 8'h02, 8'h41};

    vct_crtc vct_crtc_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .char_tick(char_tick),
        .color_mode(color_mode), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .ext_sel(ext_sel),
        .video(video), .fetch(fetch));
    vct_monitor_model vct_monitor_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .video(video), .line_len(line_len), .hs_width(hs_width), .de_width(de_width),
        .hs_off(hs_off), .frame_lines(frame_lines), .lines(lines), .bl_width(bl_width),
        .cur_clks(cur_clks));

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // One-cycle write strobe, inputs change at the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge sys_clk);
        io_wr = 1'b0;
    endtask

    task automatic setr(input logic [7:0] idx, input logic [7:0] d);
        wr(color_mode ? VCT_INDEX_COLOR : VCT_INDEX_MONO, idx);
        wr(color_mode ? VCT_DATA_COLOR : VCT_DATA_MONO, d);
    endtask

    // Index write, then a read of the data port compared with exp
    task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
        int n;
        wr(color_mode ? VCT_INDEX_COLOR : VCT_INDEX_MONO, idx);
        @(negedge sys_clk);
        io_addr = color_mode ? VCT_DATA_COLOR : VCT_DATA_MONO;
        io_rd = 1'b1;
        @(negedge sys_clk);
        io_rd = 1'b0;
        n = 0;
        while (io_rvalid !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        check(io_rvalid, 1, "read answer");
        check(io_rdata, exp, "register read");
    endtask

    // Bounded wait for a number of new scanlines
    task automatic wait_lines(input int n);
        int target;
        int k;
        target = lines + n;
        k = 0;
        while (lines < target && k < 2000) begin
            @(negedge sys_clk);
            k++;
        end
        check(lines >= target, 1, "scanline progress");
    endtask

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog, far beyond the two thousand cycles the tests need
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {sys_rst, char_tick, color_mode} = 3'b111;
        {io_wr, io_rd, io_addr, io_wdata} = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst = 1'b0;
        for (int i = 0; i < 16; i++) chk(i[7:0], VCT_REG_RESET);
        for (int i = 0; i < 16; i++) setr(i[7:0], i[7:0] * 8'h11 + 8'h03);
        for (int i = 0; i < 16; i++) chk(i[7:0], i[7:0] * 8'h11 + 8'h03);
        // Mono ports, then a stray write on the color data port
        color_mode = 1'b0;
        setr(8'h0c, 8'ha5);
        wr(VCT_DATA_COLOR, 8'h00);
        chk(8'h0c, 8'ha5);
        color_mode = 1'b1;
        chk(8'h0c, 8'ha5);
        setr(8'h10, 8'h55);
        chk(8'h10, 8'h00);
        setr(8'h03, 8'h85);
        setr(8'h10, 8'h55);
        chk(8'h10, 8'h55);
        setr(8'h11, 8'h41);
        chk(8'h11, 8'h41);
        wr(VCT_INDEX_COLOR, 8'h40);
        check(ext_sel, 1'b0, "plain bank");
        wr(VCT_INDEX_COLOR, 8'h80);
        check(ext_sel, 1'b1, "extended bank");
        chk(8'h80, 8'h00);
        // Data write while the extended bank is selected must not land
        wr(VCT_DATA_COLOR, 8'h5a);
        chk(8'h00, 8'h03);
        // Write protect keeps only the line compare bit of indices 0..7 writable
        setr(8'h11, 8'hc1);
        setr(8'h00, 8'h33);
        chk(8'h00, 8'h03);
        setr(8'h07, 8'h00);
        chk(8'h07, 8'h6a);
        setr(8'h11, 8'h41);
        for (int i = 0; i < 11; i++) setr(tidx[i], tval[i]);
        wait_lines(3);
        check(line_len, 25, "line length");
        check(de_width, 10, "display width");
        check(hs_width, 4, "hsync width");
        check(bl_width, 5, "blank width");
        wait_lines(12);
        check(frame_lines, 5, "frame height");
        // Byte panning reaches the fetch port
        setr(8'h08, 8'h43);
        repeat (2) @(negedge sys_clk);
        check(fetch.byte_pan, 2, "byte pan");
        // Cursor at the display start address, all row scans
        setr(8'h0e, 8'ha5);
        setr(8'h0f, 8'he0);
        setr(8'h0b, 8'h1f);
        setr(8'h0a, 8'h00);
        c0 = cur_clks;
        wait_lines(3);
        check(cur_clks > c0, 1, "cursor shown");
        setr(8'h0a, 8'h20);
        wait_lines(1);
        c0 = cur_clks;
        wait_lines(3);
        check(cur_clks, c0, "cursor off");
        for (int i = 0; i < 4; i++) begin
            setr(8'h05, {1'b0, i[1:0], 5'h04});
            wait_lines(3);
            check(hs_off, 14 + i, "hsync delay");
            setr(8'h05, 8'h04);
            setr(8'h03, {1'b1, i[1:0], 5'h05});
            wait_lines(3);
            check(hs_off, 14 - i, "enable skew");
            setr(8'h03, 8'h85);
        end
        print_verdict();
    end
endmodule
